// ===== shared/fifo_flag_pkg.sv
// shared constants for the fall-through flag and offset programming block
// assumes every pin is sampled by the 100 MHz system clock
package fifo_flag_pkg;

  // ---------------------------------------------------------------
  // widths and defaults
  // ---------------------------------------------------------------
  localparam int DATA_W         = 36;
  localparam int DEFAULT_DEPTH  = 1024;
  localparam int DEFAULT_OFS_W  = 10;
  localparam int DEFAULT_OFFSET = 127;
  localparam int BUF_DEPTH      = 4;
  localparam int SYNC_STAGES    = 2;
  localparam int FLAG_SETTLE    = 2;

  // ---------------------------------------------------------------
  // positions in the synchronised pin vector
  // ---------------------------------------------------------------
  localparam int PIN_WCLK = 0;
  localparam int PIN_RCLK = 1;
  localparam int PIN_MRS  = 2;
  localparam int PIN_LD   = 3;
  localparam int PIN_SEN  = 4;
  localparam int PIN_WEN  = 5;
  localparam int PIN_REN  = 6;
  localparam int PIN_SI   = 7;
  localparam int PIN_DATA = 8;
  localparam int PIN_W    = PIN_DATA + DATA_W;

  // ---------------------------------------------------------------
  // offset register parts, in load and readback order
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    EMPTY_LOW,
    EMPTY_HIGH,
    FULL_LOW,
    FULL_HIGH
  } part_type;

  function automatic part_type next_part(input part_type p);
    case (p)
      EMPTY_LOW:  next_part = EMPTY_HIGH;
      EMPTY_HIGH: next_part = FULL_LOW;
      FULL_LOW:   next_part = FULL_HIGH;
      default:    next_part = EMPTY_LOW;
    endcase
  endfunction : next_part

endpackage : fifo_flag_pkg

// ===== hdl/pin_sync.sv
// two-flip-flop synchroniser for a vector of asynchronous pins
// assumes each bit is an independent level; no word coherence given
`timescale 1ns/100ps
module pin_sync
  import fifo_flag_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys_in,  // system clock
  input  wire logic             resetn_in,   // sync reset, active low
  input  wire logic [WIDTH-1:0] pins_in,     // raw pin levels
  output logic      [WIDTH-1:0] sync_out     // synchronised levels
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= pins_in;
      sync_out <= meta;
    end
  end

endmodule : pin_sync

// ===== hdl/word_fifo.sv
// small valid/ready word buffer
// assumes DEPTH is a power of two; both sides on the same clock
`timescale 1ns/100ps
module word_fifo
  import fifo_flag_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic             clk_sys_in,  // system clock
  input  wire logic             resetn_in,   // sync reset, active low
  input  wire logic             in_valid_in, // word offered
  output logic                  in_ready_out,// room for a word
  input  wire logic [WIDTH-1:0] in_data_in,  // word to store
  output logic                  out_valid_out,// word available
  input  wire logic             out_ready_in,// drain side takes word
  output logic      [WIDTH-1:0] out_data_out // oldest word
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_out  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_ptr != rd_ptr;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule : word_fifo

// ===== hdl/fifo_flag_offset.sv
// fall-through status flags and almost-empty/almost-full offset loading
// assumes write and read clocks arrive as pins and are far slower than clk_sys_in
//
// How it works
// - almost-empty rises at empty offset plus two
// - half-full falls from half depth plus two
// - input-ready goes high at depth plus one
// - parallel load walks four offset parts in order
// - parallel readback walks four parts in order
// - serial load takes one bit per write edge
// - load method latched only during master reset
// - readback allowed in either load method
// - serial offsets take effect only when set completes
// - shift enable high blocks serial shifting
// - memory writes interleave freely with serial loading
// - almost-full valid two write edges after load
// - almost-empty valid two read edges after load
// - offsets read back only on the parallel bus
// - load select high at master reset means serial
// - master reset rewinds both part pointers
`timescale 1ns/100ps
module fifo_flag_offset
  import fifo_flag_pkg::*;
#(
  parameter int DEPTH    = DEFAULT_DEPTH,
  parameter int OFS_W    = DEFAULT_OFS_W,
  parameter int OFS_INIT = DEFAULT_OFFSET
) (
  input  wire logic              clk_sys_in,             // system clock, 100 MHz
  input  wire logic              resetn_in,              // sync reset, active low
  input  wire logic              write_clk_in,           // writer clock pin
  input  wire logic              read_clk_in,            // reader clock pin
  input  wire logic              master_reset_n_in,      // master reset pin
  input  wire logic              offset_load_select_n_in,// offset access select
  input  wire logic              shift_enable_n_in,      // serial shift enable
  input  wire logic              write_enable_n_in,      // write enable
  input  wire logic              read_enable_n_in,       // read enable
  input  wire logic              serial_in,              // serial offset bit
  input  wire logic [DATA_W-1:0] input_bus_in,           // write data / offsets
  output logic      [DATA_W-1:0] output_bus_out,         // read data / offsets
  output logic                   input_ready_n_out,      // high when full
  output logic                   output_ready_n_out,     // high when empty
  output logic                   almost_empty_flag_n_out,// low when near empty
  output logic                   almost_full_flag_n_out, // low when near full
  output logic                   half_full_flag_n_out,   // low from half depth plus two
  output logic                   serial_mode_out         // method latched at reset
);

  // ---------------------------------------------------------------
  // derived sizes
  // ---------------------------------------------------------------
  localparam int CNT_W   = $clog2(DEPTH + 2);
  localparam int PART_W  = (OFS_W + 1) / 2;
  localparam int HIGH_W  = OFS_W - PART_W;
  localparam int SET_W   = 2 * OFS_W;
  localparam int IDX_W   = $clog2(SET_W);
  localparam int SET_W_T = $clog2(FLAG_SETTLE + 1);

  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH + 1);
  localparam logic [CNT_W-1:0] HALF_MARK  = CNT_W'(DEPTH / 2 + 2);
  localparam logic [IDX_W-1:0] LAST_BIT   = IDX_W'(SET_W - 1);
  localparam logic [OFS_W-1:0] OFS_RESET  = OFS_W'(OFS_INIT);
  localparam logic [SET_W_T-1:0] SETTLE_LAST = SET_W_T'(FLAG_SETTLE - 1);

  function automatic logic at_least(input logic [CNT_W-1:0] c,
                                    input logic [CNT_W-1:0] thr);
    at_least = c >= thr;
  endfunction : at_least

  // ---------------------------------------------------------------
  // pin sampling and edge finding
  // ---------------------------------------------------------------
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pins_s;
  logic             wclk_prev;
  logic             rclk_prev;
  logic             wclk_rise;
  logic             rclk_rise;
  logic             mrs_act;
  logic             ld_n;
  logic             sen_n;
  logic             wen_n;
  logic             ren_n;
  logic             si;
  logic [DATA_W-1:0] din;

  assign pins = {input_bus_in, serial_in, read_enable_n_in, write_enable_n_in,
                 shift_enable_n_in, offset_load_select_n_in, master_reset_n_in,
                 read_clk_in, write_clk_in};

  pin_sync #(
    .WIDTH (PIN_W)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .pins_in    (pins),
    .sync_out   (pins_s)
  );

  assign mrs_act   = !pins_s[PIN_MRS];
  assign ld_n      = pins_s[PIN_LD];
  assign sen_n     = pins_s[PIN_SEN];
  assign wen_n     = pins_s[PIN_WEN];
  assign ren_n     = pins_s[PIN_REN];
  assign si        = pins_s[PIN_SI];
  assign din       = pins_s[PIN_DATA +: DATA_W];
  assign wclk_rise = pins_s[PIN_WCLK] && !wclk_prev;
  assign rclk_rise = pins_s[PIN_RCLK] && !rclk_prev;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      wclk_prev <= 1'b0;
      rclk_prev <= 1'b0;
    end else begin
      wclk_prev <= pins_s[PIN_WCLK];
      rclk_prev <= pins_s[PIN_RCLK];
    end
  end

  // ---------------------------------------------------------------
  // operation decode on clock edges
  // ---------------------------------------------------------------
  logic serial_mode;
  logic ofs_write;
  logic ofs_read;
  logic bit_shift;
  logic mem_write;
  logic mem_read;

  assign ofs_write = wclk_rise && !ld_n && !wen_n && ren_n && sen_n
                     && !serial_mode;
  assign ofs_read  = rclk_rise && !ld_n && !ren_n && wen_n && sen_n;
  assign bit_shift = wclk_rise && !ld_n && !sen_n && serial_mode;
  assign mem_write = wclk_rise && ld_n && !wen_n;
  assign mem_read  = rclk_rise && ld_n && !ren_n;

  // programming method is caught only while master reset is held
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      serial_mode <= 1'b0;
    end else if (mrs_act) begin
      serial_mode <= ld_n;
    end
  end

  // ---------------------------------------------------------------
  // offset registers, part pointers and serial staging
  // ---------------------------------------------------------------
  logic [OFS_W-1:0] empty_ofs;
  logic [OFS_W-1:0] full_ofs;
  part_type         wr_part;
  part_type         rd_part;
  logic [SET_W-1:0] shadow;
  logic [IDX_W-1:0] bit_idx;
  logic             empty_done;
  logic             full_done;
  logic [SET_W-1:0] next_shadow;

  always_comb begin
    next_shadow          = shadow;
    next_shadow[bit_idx] = si;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      empty_ofs  <= OFS_RESET;
      full_ofs   <= OFS_RESET;
      wr_part    <= EMPTY_LOW;
      shadow     <= '0;
      bit_idx    <= '0;
      empty_done <= 1'b0;
      full_done  <= 1'b0;
    end else if (mrs_act) begin
      empty_ofs  <= OFS_RESET;
      full_ofs   <= OFS_RESET;
      wr_part    <= EMPTY_LOW;
      bit_idx    <= '0;
      empty_done <= 1'b0;
      full_done  <= 1'b0;
    end else begin
      empty_done <= 1'b0;
      full_done  <= 1'b0;
      if (ofs_write) begin
        wr_part <= next_part(wr_part);
        case (wr_part)
          EMPTY_LOW:  empty_ofs[PART_W-1:0]     <= din[PART_W-1:0];
          EMPTY_HIGH: begin
            empty_ofs[OFS_W-1:PART_W] <= din[HIGH_W-1:0];
            empty_done                <= 1'b1;
          end
          FULL_LOW:   full_ofs[PART_W-1:0]      <= din[PART_W-1:0];
          default: begin
            full_ofs[OFS_W-1:PART_W]  <= din[HIGH_W-1:0];
            full_done                 <= 1'b1;
          end
        endcase
      end else if (bit_shift) begin
        // staged so a partial set never disturbs the live offsets
        shadow <= next_shadow;
        if (bit_idx == LAST_BIT) begin
          bit_idx    <= '0;
          empty_ofs  <= next_shadow[OFS_W-1:0];
          full_ofs   <= next_shadow[SET_W-1:OFS_W];
          empty_done <= 1'b1;
          full_done  <= 1'b1;
        end else begin
          bit_idx <= bit_idx + 1'b1;
        end
      end
    end
  end

  // readback pointer and the parallel bus view of the offsets
  logic [DATA_W-1:0] readback;
  logic              readback_hit;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      rd_part      <= EMPTY_LOW;
      readback     <= '0;
      readback_hit <= 1'b0;
    end else if (mrs_act) begin
      rd_part      <= EMPTY_LOW;
      readback_hit <= 1'b0;
    end else begin
      readback_hit <= ofs_read;
      if (ofs_read) begin
        rd_part <= next_part(rd_part);
        case (rd_part)
          EMPTY_LOW:  readback <= DATA_W'(empty_ofs[PART_W-1:0]);
          EMPTY_HIGH: readback <= DATA_W'(empty_ofs[OFS_W-1:PART_W]);
          FULL_LOW:   readback <= DATA_W'(full_ofs[PART_W-1:0]);
          default:    readback <= DATA_W'(full_ofs[OFS_W-1:PART_W]);
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // flag offsets settle a fixed number of port clock edges after load
  // ---------------------------------------------------------------
  logic [OFS_W-1:0]   af_ofs;
  logic [OFS_W-1:0]   ae_ofs;
  logic               af_wait;
  logic               ae_wait;
  logic [SET_W_T-1:0] af_edges;
  logic [SET_W_T-1:0] ae_edges;

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || mrs_act) begin
      af_ofs   <= OFS_RESET;
      af_wait  <= 1'b0;
      af_edges <= '0;
    end else if (full_done) begin
      af_wait  <= 1'b1;
      af_edges <= '0;
    end else if (af_wait && wclk_rise) begin
      if (af_edges == SETTLE_LAST) begin
        af_wait <= 1'b0;
        af_ofs  <= full_ofs;
      end else begin
        af_edges <= af_edges + 1'b1;
      end
    end
  end

  // read edges are counted here, so a stopped read clock holds the old offset
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || mrs_act) begin
      ae_ofs   <= OFS_RESET;
      ae_wait  <= 1'b0;
      ae_edges <= '0;
    end else if (empty_done) begin
      ae_wait  <= 1'b1;
      ae_edges <= '0;
    end else if (ae_wait && rclk_rise) begin
      if (ae_edges == SETTLE_LAST) begin
        ae_wait <= 1'b0;
        ae_ofs  <= empty_ofs;
      end else begin
        ae_edges <= ae_edges + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // write staging buffer and occupancy count
  // ---------------------------------------------------------------
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic [DATA_W-1:0] buf_out_data;
  logic              drain;
  logic [CNT_W-1:0]  count;
  logic [DATA_W-1:0] last_word;
  logic              dec;

  // a write at full is dropped; buffering it would let it land after a read
  assign drain = buf_out_valid && (count != FULL_COUNT);
  assign dec   = mem_read && (count != '0);

  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_sys_in    (clk_sys_in),
    .resetn_in     (resetn_in && !mrs_act),
    .in_valid_in   (mem_write && count != FULL_COUNT),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (din),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (drain),
    .out_data_out  (buf_out_data)
  );

  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in || mrs_act) begin
      count     <= '0;
      last_word <= '0;
    end else begin
      if (drain) begin
        last_word <= buf_out_data;
      end
      if (drain && !dec) begin
        count <= count + 1'b1;
      end else if (dec && !drain) begin
        count <= count - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      output_bus_out          <= '0;
      input_ready_n_out       <= 1'b1;
      output_ready_n_out      <= 1'b1;
      almost_empty_flag_n_out <= 1'b0;
      almost_full_flag_n_out  <= 1'b1;
      half_full_flag_n_out    <= 1'b1;
      serial_mode_out         <= 1'b0;
    end else begin
      serial_mode_out    <= serial_mode;
      output_ready_n_out <= (count == '0);
      almost_empty_flag_n_out <=
        at_least(count, CNT_W'(ae_ofs) + CNT_W'(2));
      half_full_flag_n_out <= !at_least(count, HALF_MARK);
      almost_full_flag_n_out <=
        !at_least(count, FULL_COUNT - CNT_W'(af_ofs));
      input_ready_n_out <= (count == FULL_COUNT) || !buf_in_ready;
      // offset readback overwrites whatever word stood on the bus
      if (readback_hit) begin
        output_bus_out <= readback;
      end else if (mem_read && count != '0) begin
        output_bus_out <= last_word;
      end
    end
  end

endmodule : fifo_flag_offset

// ===== verif/fifo_flag_chk.sv
// pin-level assertions for the fall-through flag and offset block
// assumes it is bound onto fifo_flag_offset and pin clocks are slow
`timescale 1ns/100ps
module fifo_flag_chk
  import fifo_flag_pkg::*;
(
  input wire logic              clk_sys_in,              // system clock
  input wire logic              resetn_in,               // sync reset
  input wire logic              write_clk_in,            // writer clock pin
  input wire logic              read_clk_in,             // reader clock pin
  input wire logic              master_reset_n_in,       // master reset pin
  input wire logic              offset_load_select_n_in, // load select pin
  input wire logic [DATA_W-1:0] output_bus_out,          // read bus
  input wire logic              input_ready_n_out,       // full flag
  input wire logic              output_ready_n_out,      // empty flag
  input wire logic              almost_empty_flag_n_out, // near empty
  input wire logic              almost_full_flag_n_out,  // near full
  input wire logic              half_full_flag_n_out,    // half full
  input wire logic              serial_mode_out          // load method
);
  // ------------------------------------------------------------
  // pin history
  // ------------------------------------------------------------
  // raw pins, so windows allow for the two sync flops inside
  logic [7:0] wc_h;
  logic [7:0] rc_h;
  logic [7:0] mr_h;
  logic [6:0] w_rise;
  logic [6:0] r_rise;
  always_ff @(posedge clk_sys_in) begin
    wc_h <= {wc_h[6:0], write_clk_in};
    rc_h <= {rc_h[6:0], read_clk_in};
    mr_h <= {mr_h[6:0], master_reset_n_in};
  end
  assign w_rise = wc_h[6:0] & ~wc_h[7:1];
  assign r_rise = rc_h[6:0] & ~rc_h[7:1];

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_full_flags: assert property (
    input_ready_n_out && $past(resetn_in) |->
    !almost_full_flag_n_out && !half_full_flag_n_out && almost_empty_flag_n_out)
    else $error("full without matching flags");
  a_empty_flags: assert property (
    output_ready_n_out && $past(resetn_in) |-> !almost_empty_flag_n_out &&
    half_full_flag_n_out && almost_full_flag_n_out && !input_ready_n_out)
    else $error("empty without matching flags");
  a_half_ready: assert property (!half_full_flag_n_out |-> !output_ready_n_out)
    else $error("half full while empty");
  a_near_empty: assert property ($rose(almost_empty_flag_n_out) |->
    (|w_rise) || (|r_rise))
    else $error("near-empty cleared without a pin edge");
  a_mode_hold: assert property ($changed(serial_mode_out) |-> !(&mr_h))
    else $error("load method changed outside master reset");
  a_mode_follow: assert property (
    (!master_reset_n_in && $stable(offset_load_select_n_in))[*6] |->
    serial_mode_out == offset_load_select_n_in)
    else $error("load method does not follow select");
  a_bus_cause: assert property ($changed(output_bus_out) |->
    (|r_rise) || !(&mr_h))
    else $error("read bus changed without read edge");
  a_full_cause: assert property ($rose(input_ready_n_out) |-> |w_rise)
    else $error("full without write edge");
  a_af_cause: assert property ($fell(almost_full_flag_n_out) |-> |w_rise)
    else $error("near-full without write edge");

  c_full: cover property ($rose(input_ready_n_out));
  c_half: cover property ($fell(half_full_flag_n_out));
  c_serial: cover property ($rose(serial_mode_out));
endmodule : fifo_flag_chk

bind fifo_flag_offset fifo_flag_chk i_chk (
  .clk_sys_in, .resetn_in, .write_clk_in, .read_clk_in, .master_reset_n_in,
  .offset_load_select_n_in, .output_bus_out, .input_ready_n_out, .output_ready_n_out,
  .almost_empty_flag_n_out, .almost_full_flag_n_out, .half_full_flag_n_out,
  .serial_mode_out
);

// ===== verif/pin_partner.sv
// writer and reader logic on the far side of the flag block pins
// assumes clk_sys_in only paces it; pin clocks stand still between cycles
`timescale 1ns/100ps
module pin_partner
  import fifo_flag_pkg::*;
(
  input  wire logic              clk_sys_in,  // pacing clock
  output logic                   wr_clk_out,  // writer clock
  output logic                   rd_clk_out,  // reader clock
  output logic                   load_n_out,  // offset access select
  output logic                   shift_n_out, // serial shift enable
  output logic                   wr_en_n_out, // write enable
  output logic                   rd_en_n_out, // read enable
  output logic                   ser_out,     // serial offset bit
  output logic      [DATA_W-1:0] data_out     // write bus
);
  // ------------------------------------------------------------
  // pin cycles
  // ------------------------------------------------------------
  initial begin
    {wr_clk_out, rd_clk_out, ser_out} = 3'b000;
    {load_n_out, shift_n_out, wr_en_n_out, rd_en_n_out} = 4'hf;
    data_out = '0;
  end

  // ctl is {load, shift, write, read}, all active low
  task automatic hold(input logic [3:0] ctl);
    @(negedge clk_sys_in);
    {load_n_out, shift_n_out, wr_en_n_out, rd_en_n_out} = ctl;
  endtask : hold

  // one 80 ns pin clock, qualifiers held 40 ns either side of the edge
  task automatic pulse(input logic rd, input logic [3:0] ctl, input logic bit_v,
                       input logic [DATA_W-1:0] w);
    hold(ctl);
    ser_out = bit_v;
    data_out = w;
    repeat (4) @(negedge clk_sys_in);
    if (rd) rd_clk_out = 1'b1;
    else wr_clk_out = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    wr_clk_out = 1'b0;
    rd_clk_out = 1'b0;
    {load_n_out, shift_n_out, wr_en_n_out, rd_en_n_out} = 4'hf;
    // released lines must not keep the old level
    ser_out = ~ser_out;
    data_out = ~data_out;
  endtask : pulse
endmodule : pin_partner

// ===== verif/testbench.sv
// self-checking bench for the fall-through flag and offset block
// assumes a 16-word part with 10-bit offsets and a reset offset of 3
`timescale 1ns/100ps
module testbench;
  import fifo_flag_pkg::*;
  localparam int DEP  = 16;
  localparam int OFS0 = 3;
  typedef struct {logic [DATA_W-1:0] exp; int kind;} note_type;

  logic clk_sys_in, resetn_in, mrst_n, wclk, rclk, load_n, shift_n, wr_n, rd_n, ser;
  logic [DATA_W-1:0] din, bus;
  logic ir_n, or_n, ae_n, af_n, hf_n, smode;
  note_type notes[$];
  event settle_ev;
  integer seed = 32'h0000_edf4;
  int failures = 0;
  int checks = 0;
  int cnt, cur_n, cur_m, nn, mm;

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    resetn_in = 1'b0;
    mrst_n = 1'b0;
  end

  fifo_flag_offset #(.DEPTH(DEP), .OFS_INIT(OFS0)) i_dut (
    .clk_sys_in, .resetn_in, .write_clk_in(wclk), .read_clk_in(rclk),
    .master_reset_n_in(mrst_n), .offset_load_select_n_in(load_n),
    .shift_enable_n_in(shift_n), .write_enable_n_in(wr_n), .read_enable_n_in(rd_n),
    .serial_in(ser), .input_bus_in(din), .output_bus_out(bus), .input_ready_n_out(ir_n),
    .output_ready_n_out(or_n), .almost_empty_flag_n_out(ae_n),
    .almost_full_flag_n_out(af_n), .half_full_flag_n_out(hf_n), .serial_mode_out(smode));

  pin_partner i_partner (
    .clk_sys_in, .wr_clk_out(wclk), .rd_clk_out(rclk), .load_n_out(load_n),
    .shift_n_out(shift_n), .wr_en_n_out(wr_n), .rd_en_n_out(rd_n), .ser_out(ser),
    .data_out(din));

  // ------------------------------------------------------------
  // expectations and scoreboard
  // ------------------------------------------------------------
  // {full, empty, near-empty, near-full, half}; full and empty are high when set, the other three active low on the pins
  function automatic logic [4:0] flag_exp(input int c, input int n, input int m);
    flag_exp = {c == DEP + 1, c == 0, c >= n + 2, c < DEP + 1 - m, c < DEP / 2 + 2};
  endfunction : flag_exp

  function automatic int part(input int n, input int m, input int i);
    part = ((i < 2 ? n : m) >> (5 * (i % 2))) & 31;
  endfunction : part

  task automatic note(input logic [DATA_W-1:0] e, input int k);
    notes.push_back('{e, k});
  endtask : note

  task automatic settle;
    repeat (6) @(negedge clk_sys_in);
    -> settle_ev;
    @(negedge clk_sys_in);
  endtask : settle

  initial begin : monitor
    note_type nt;
    logic [DATA_W-1:0] seen;
    forever begin
      @(settle_ev);
      while (notes.size() > 0) begin
        nt = notes.pop_front();
        seen = nt.kind == 1 ? DATA_W'({ir_n, or_n, ae_n, af_n, hf_n}) :
               nt.kind == 2 ? DATA_W'(smode) : bus;
        checks++;
        if (seen !== nt.exp) begin
          failures++;
          $display("[ERR] %s expected %h seen %h",
                   nt.kind == 1 ? "flags" : nt.kind == 2 ? "serial_mode" : "output_bus",
                   nt.exp, seen);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // pin sequences
  // ------------------------------------------------------------
  task automatic mreset(input logic sel);
    i_partner.hold({sel, 3'b111});
    mrst_n = 1'b0;
    repeat (6) @(negedge clk_sys_in);
    mrst_n = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    i_partner.hold(4'b1111);
    {cnt, cur_n, cur_m} = {32'd0, OFS0, OFS0};
    note(DATA_W'(sel), 2);
  endtask : mreset

  task automatic read_ofs(input int n, input int m);
    for (int i = 0; i < 4; i++) begin
      i_partner.pulse(1'b1, 4'b0110, 1'b0, '0);
      note(DATA_W'(part(n, m, i)), 0);
      settle();
    end
  endtask : read_ofs

  task automatic write_ofs(input int n, input int m);
    for (int i = 0; i < 4; i++) i_partner.pulse(1'b0, 4'b0101, 1'b0, DATA_W'(part(n, m, i)));
  endtask : write_ofs

  task automatic shift_set(input int n, input int m, input int lo, input int hi);
    logic [19:0] set;
    set = {m[9:0], n[9:0]};
    for (int b = lo; b <= hi; b++) i_partner.pulse(1'b0, 4'b0011, set[b], '0);
  endtask : shift_set

  task automatic mem_op(input logic rd);
    i_partner.pulse(rd, rd ? 4'b1110 : 4'b1101, 1'b0,
                    DATA_W'({$random(seed), $random(seed)}));
    if (rd && cnt > 0) cnt--;
    else if (!rd && cnt < DEP + 1) cnt++;
    note(DATA_W'(flag_exp(cnt, cur_n, cur_m)), 1);
    settle();
  endtask : mem_op

  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial begin : watchdog
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin : main
    repeat (12) @(negedge clk_sys_in);
    resetn_in = 1'b1;
    mreset(1'b0);
    note(DATA_W'(flag_exp(0, OFS0, OFS0)), 1);
    settle();
    read_ofs(OFS0, OFS0);
    cur_n = {$random(seed)} % 12;
    cur_m = {$random(seed)} % 15;
    write_ofs(cur_n, cur_m);
    read_ofs(cur_n, cur_m);
    repeat (DEP + 2) mem_op(1'b0);
    repeat (DEP + 2) mem_op(1'b1);
    mreset(1'b1);
    mem_op(1'b0);
    nn = {$random(seed)} % 12;
    mm = {$random(seed)} % 15;
    write_ofs(nn, mm);
    shift_set(nn, mm, 0, 9);
    i_partner.pulse(1'b0, 4'b0111, 1'b1, '0);
    i_partner.pulse(1'b0, 4'b1011, 1'b0, '0);
    mem_op(1'b0);
    read_ofs(OFS0, OFS0);
    shift_set(nn, mm, 10, 19);
    repeat (2) i_partner.pulse(1'b0, 4'b1111, 1'b0, '0);
    {cur_n, cur_m} = {nn, mm};
    read_ofs(nn, mm);
    mem_op(1'b0);
    i_partner.hold(4'b0111);
    note(DATA_W'(1'b1), 2);
    settle();
    finish_test();
  end
endmodule : testbench
